// ===== rtl/ext_flag_jump_pkg.sv
// Shared constants and types for the extend, set-flags and jump execute block.
`default_nettype none

package ext_flag_jump_pkg;

    // ------------------------------------------------------------
    // Operand masks and auxiliary addresses
    // ------------------------------------------------------------
    localparam logic [31:0] BYTE_MASK   = 32'h0000_00ff;
    localparam logic [31:0] HALF_MASK   = 32'h0000_ffff;
    localparam logic [31:0] ADDR_LEGACY = 32'h0000_0000;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_000a;
    localparam logic [31:0] STATUS_RST  = 32'h0000_0000;
    localparam logic [31:0] KEEP_MASK   = 32'h0000_10f8;
    localparam logic [24:0] LEG_ZERO    = 25'h000_0000;

    // ------------------------------------------------------------
    // Status word bit positions
    // ------------------------------------------------------------
    localparam int unsigned SB_H  = 0;
    localparam int unsigned SB_E1 = 1;
    localparam int unsigned SB_E2 = 2;
    localparam int unsigned SB_DE = 6;
    localparam int unsigned SB_U  = 7;
    localparam int unsigned SB_V  = 8;
    localparam int unsigned SB_C  = 9;
    localparam int unsigned SB_N  = 10;
    localparam int unsigned SB_Z  = 11;

    // ------------------------------------------------------------
    // Condition codes
    // ------------------------------------------------------------
    localparam logic [4:0] CC_AL  = 5'h00;
    localparam logic [4:0] CC_EQ  = 5'h01;
    localparam logic [4:0] CC_NE  = 5'h02;
    localparam logic [4:0] CC_PL  = 5'h03;
    localparam logic [4:0] CC_MI  = 5'h04;
    localparam logic [4:0] CC_CS  = 5'h05;
    localparam logic [4:0] CC_CC  = 5'h06;
    localparam logic [4:0] CC_VS  = 5'h07;
    localparam logic [4:0] CC_VC  = 5'h08;
    localparam logic [4:0] CC_GT  = 5'h09;
    localparam logic [4:0] CC_GE  = 5'h0a;
    localparam logic [4:0] CC_LT  = 5'h0b;
    localparam logic [4:0] CC_LE  = 5'h0c;
    localparam logic [4:0] CC_HI  = 5'h0d;
    localparam logic [4:0] CC_LS  = 5'h0e;
    localparam logic [4:0] CC_PNZ = 5'h0f;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        op_none,
        zero_extend_byte_op,
        zero_extend_half_op,
        op_set_flags,
        op_jump,
        op_other
    } op_kind_t;

    typedef enum logic [0:0] {
        ph_idle,
        ph_settle
    } phase_t;

    typedef struct packed {
        op_kind_t    kind;
        logic        flag_sfx;
        logic        delay_sfx;
        logic [4:0]  cond;
        logic [31:0] src;
        logic        src_link1;
        logic        src_link2;
        logic        is_branch;
        logic        is_loop;
        logic        is_irq_return;
        logic        has_limm;
    } instr_t;

    typedef struct packed {
        logic [31:0] level1_saved_status;
        logic [31:0] level2_saved_status;
        logic [31:0] level1_saved_target;
        logic [31:0] level2_saved_target;
    } saved_ctx_t;

    typedef struct packed {
        logic        taken;
        logic [31:0] target;
        logic        run_slot;
        logic        resume_delayed;
    } jump_t;

    typedef struct packed {
        phase_t      phase;
        logic [31:0] status;
        logic [31:0] branch_target_reg;
        logic        slot_pend;
        logic [31:0] dest;
        logic        dest_we;
        logic [31:0] rdata;
        jump_t       jump;
        logic        illegal;
        logic        ierr;
    } state_t;

endpackage : ext_flag_jump_pkg

`default_nettype wire

// ===== rtl/cond_eval.sv
// Decoder of the five-bit jump condition field against the status flags.
`default_nettype none

module cond_eval (
    input  wire logic [4:0] code_i,
    input  wire logic       z_i,
    input  wire logic       n_i,
    input  wire logic       c_i,
    input  wire logic       v_i,
    output logic            hit_o
);

    // ------------------------------------------------------------
    // Condition table
    // ------------------------------------------------------------
    always_comb begin
        unique case (code_i)
            ext_flag_jump_pkg::CC_AL:  hit_o = 1'b1;
            ext_flag_jump_pkg::CC_EQ:  hit_o = z_i;
            ext_flag_jump_pkg::CC_NE:  hit_o = !z_i;
            ext_flag_jump_pkg::CC_PL:  hit_o = !n_i;
            ext_flag_jump_pkg::CC_MI:  hit_o = n_i;
            ext_flag_jump_pkg::CC_CS:  hit_o = c_i;
            ext_flag_jump_pkg::CC_CC:  hit_o = !c_i;
            ext_flag_jump_pkg::CC_VS:  hit_o = v_i;
            ext_flag_jump_pkg::CC_VC:  hit_o = !v_i;
            ext_flag_jump_pkg::CC_GT:  hit_o = (n_i == v_i) && !z_i;
            ext_flag_jump_pkg::CC_GE:  hit_o = (n_i == v_i);
            ext_flag_jump_pkg::CC_LT:  hit_o = (n_i != v_i);
            ext_flag_jump_pkg::CC_LE:  hit_o = z_i || (n_i != v_i);
            ext_flag_jump_pkg::CC_HI:  hit_o = !c_i && !z_i;
            ext_flag_jump_pkg::CC_LS:  hit_o = c_i || z_i;
            ext_flag_jump_pkg::CC_PNZ: hit_o = !n_i && !z_i;
            default:                   hit_o = 1'b0;
        endcase
    end

endmodule : cond_eval

`default_nettype wire

// ===== rtl/ext_flag_jump_execute.sv
// Execute logic for zero extension, set-flags and jump instructions.
`default_nettype none

module ext_flag_jump_execute (
    input  wire logic                          clk_i,
    input  wire logic                          reset_n_i,
    input  wire logic                          instr_valid_i,
    input  wire ext_flag_jump_pkg::instr_t     instr_i,
    output logic                               instr_ready_o,
    input  wire ext_flag_jump_pkg::saved_ctx_t saved_i,
    input  wire logic                          aux_wr_i,
    input  wire logic                          aux_rd_i,
    input  wire logic [31:0]                   aux_addr_i,
    input  wire logic [31:0]                   aux_wdata_i,
    output logic [31:0]                        aux_rdata_o,
    output logic [31:0]                        dest_o,
    output logic                               dest_we_o,
    output ext_flag_jump_pkg::jump_t           jump_o,
    output logic [31:0]                        processor_status_word_o,
    output logic [31:0]                        legacy_status_word_o,
    output logic [31:0]                        branch_target_reg_o,
    output logic                               irq_hold_o,
    output logic                               core_halt_o,
    output logic                               illegal_seq_o,
    output logic                               instr_error_o
);

    // ------------------------------------------------------------
    // State and decode signals
    // ------------------------------------------------------------
    ext_flag_jump_pkg::state_t cur_r;
    ext_flag_jump_pkg::state_t cur_nxt;
    logic                      accept;
    logic                      kernel;
    logic                      hit;
    logic                      is_link;
    logic                      seq_bad;
    logic [31:0]               ext_val;
    logic [31:0]               legacy_view;

    assign kernel = !cur_r.status[ext_flag_jump_pkg::SB_U];
    assign instr_ready_o = (cur_r.phase == ext_flag_jump_pkg::ph_idle)
                           && !cur_r.status[ext_flag_jump_pkg::SB_H];
    assign accept = instr_valid_i && instr_ready_o;
    assign is_link = instr_i.src_link1 || instr_i.src_link2;

    // An executed delay slot may not hold a transfer or a long immediate.
    assign seq_bad = cur_r.slot_pend
                     && ((instr_i.kind == ext_flag_jump_pkg::op_jump)
                         || instr_i.is_branch || instr_i.is_loop
                         || instr_i.is_irq_return || instr_i.has_limm);

    assign ext_val = (instr_i.kind == ext_flag_jump_pkg::zero_extend_byte_op)
                     ? (instr_i.src & ext_flag_jump_pkg::BYTE_MASK)
                     : (instr_i.src & ext_flag_jump_pkg::HALF_MASK);

    // The legacy word mirrors the status flags in its top bits.
    assign legacy_view = {cur_r.status[ext_flag_jump_pkg::SB_Z:ext_flag_jump_pkg::SB_V],
                          cur_r.status[ext_flag_jump_pkg::SB_E2:ext_flag_jump_pkg::SB_H],
                          ext_flag_jump_pkg::LEG_ZERO};

    // ------------------------------------------------------------
    // Condition decode
    // ------------------------------------------------------------
    cond_eval u_cond (
        .code_i (instr_i.cond),
        .z_i    (cur_r.status[ext_flag_jump_pkg::SB_Z]),
        .n_i    (cur_r.status[ext_flag_jump_pkg::SB_N]),
        .c_i    (cur_r.status[ext_flag_jump_pkg::SB_C]),
        .v_i    (cur_r.status[ext_flag_jump_pkg::SB_V]),
        .hit_o  (hit)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        cur_nxt = cur_r;
        cur_nxt.dest_we = 1'b0;
        cur_nxt.jump.taken = 1'b0;
        cur_nxt.jump.run_slot = 1'b0;
        cur_nxt.jump.resume_delayed = 1'b0;
        cur_nxt.illegal = 1'b0;
        cur_nxt.ierr = 1'b0;
        if (cur_r.phase == ext_flag_jump_pkg::ph_settle) begin
            cur_nxt.phase = ext_flag_jump_pkg::ph_idle;
        end
        if (aux_wr_i && (aux_addr_i == ext_flag_jump_pkg::ADDR_STATUS)) begin
            cur_nxt.status = aux_wdata_i;
        end
        if (aux_rd_i) begin
            if (aux_addr_i == ext_flag_jump_pkg::ADDR_STATUS) begin
                cur_nxt.rdata = cur_r.status;
            end else if (aux_addr_i == ext_flag_jump_pkg::ADDR_LEGACY) begin
                cur_nxt.rdata = legacy_view;
            end else begin
                cur_nxt.rdata = '0;
            end
        end
        if (accept) begin
            cur_nxt.slot_pend = 1'b0;
            if (seq_bad) begin
                cur_nxt.illegal = 1'b1;
            end else begin
                unique case (instr_i.kind)
                    ext_flag_jump_pkg::zero_extend_byte_op,
                    ext_flag_jump_pkg::zero_extend_half_op: begin
                        cur_nxt.dest = ext_val;
                        cur_nxt.dest_we = 1'b1;
                        if (instr_i.flag_sfx) begin
                            cur_nxt.status[ext_flag_jump_pkg::SB_Z] = (ext_val == '0);
                            cur_nxt.status[ext_flag_jump_pkg::SB_N] = 1'b0;
                        end
                    end
                    ext_flag_jump_pkg::op_set_flags: begin
                        cur_nxt.phase = ext_flag_jump_pkg::ph_settle;
                        if (instr_i.src[ext_flag_jump_pkg::SB_H] && kernel) begin
                            cur_nxt.status[ext_flag_jump_pkg::SB_H] = 1'b1;
                        end else begin
                            cur_nxt.status[ext_flag_jump_pkg::SB_Z:ext_flag_jump_pkg::SB_V] =
                                instr_i.src[ext_flag_jump_pkg::SB_Z:ext_flag_jump_pkg::SB_V];
                            if (kernel) begin
                                cur_nxt.status[ext_flag_jump_pkg::SB_E2:ext_flag_jump_pkg::SB_E1] =
                                    instr_i.src[ext_flag_jump_pkg::SB_E2:ext_flag_jump_pkg::SB_E1];
                            end
                        end
                    end
                    ext_flag_jump_pkg::op_jump: begin
                        if (is_link != instr_i.flag_sfx) begin
                            cur_nxt.ierr = 1'b1;
                        end else begin
                            cur_nxt.slot_pend = instr_i.delay_sfx;
                            if (hit) begin
                                cur_nxt.jump.taken = 1'b1;
                                cur_nxt.jump.target = {instr_i.src[31:1], 1'b0};
                                cur_nxt.jump.run_slot = instr_i.delay_sfx;
                                if (instr_i.src_link1) begin
                                    cur_nxt.status = saved_i.level1_saved_status;
                                    cur_nxt.branch_target_reg = saved_i.level1_saved_target;
                                end else if (instr_i.src_link2) begin
                                    cur_nxt.status = saved_i.level2_saved_status;
                                    cur_nxt.branch_target_reg = saved_i.level2_saved_target;
                                end
                                cur_nxt.jump.resume_delayed = is_link
                                    && cur_nxt.status[ext_flag_jump_pkg::SB_DE];
                            end else begin
                                cur_nxt.jump.run_slot = 1'b1;
                            end
                        end
                    end
                    ext_flag_jump_pkg::op_none,
                    ext_flag_jump_pkg::op_other: begin
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cur_r <= '{
                phase:   ext_flag_jump_pkg::ph_idle,
                status:  ext_flag_jump_pkg::STATUS_RST,
                default: '0
            };
        end else begin
            cur_r <= cur_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign aux_rdata_o = cur_r.rdata;
    assign dest_o = cur_r.dest;
    assign dest_we_o = cur_r.dest_we;
    assign jump_o = cur_r.jump;
    assign processor_status_word_o = cur_r.status;
    assign legacy_status_word_o = legacy_view;
    assign branch_target_reg_o = cur_r.branch_target_reg;
    assign core_halt_o = cur_r.status[ext_flag_jump_pkg::SB_H];
    assign illegal_seq_o = cur_r.illegal;
    assign instr_error_o = cur_r.ierr;
    assign irq_hold_o = (accept && (instr_i.kind == ext_flag_jump_pkg::op_set_flags))
                        || (cur_r.phase == ext_flag_jump_pkg::ph_settle);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    a_zext_byte_value: assert property (
        accept && !seq_bad && (instr_i.kind == ext_flag_jump_pkg::zero_extend_byte_op)
        |=> dest_we_o && (dest_o == ($past(instr_i.src) & ext_flag_jump_pkg::BYTE_MASK)))
        else $error("byte extend result wrong");

    a_zext_half_value: assert property (
        accept && !seq_bad && (instr_i.kind == ext_flag_jump_pkg::zero_extend_half_op)
        |=> dest_we_o && (dest_o == ($past(instr_i.src) & ext_flag_jump_pkg::HALF_MASK)))
        else $error("half extend result wrong");

    a_zext_flag_effect: assert property (
        accept && !seq_bad && !aux_wr_i
        && ((instr_i.kind == ext_flag_jump_pkg::zero_extend_byte_op)
            || (instr_i.kind == ext_flag_jump_pkg::zero_extend_half_op))
        |=> (processor_status_word_o[ext_flag_jump_pkg::SB_N]
             == ($past(instr_i.flag_sfx) ? 1'b0 : $past(cur_r.status[ext_flag_jump_pkg::SB_N])))
            && (processor_status_word_o[ext_flag_jump_pkg::SB_Z]
             == ($past(instr_i.flag_sfx) ? (dest_o == '0)
                 : $past(cur_r.status[ext_flag_jump_pkg::SB_Z]))))
        else $error("extend flag update wrong");

    a_flag_cond_codes: assert property (
        accept && !seq_bad && (instr_i.kind == ext_flag_jump_pkg::op_set_flags)
        && !(instr_i.src[ext_flag_jump_pkg::SB_H] && kernel)
        |=> processor_status_word_o[ext_flag_jump_pkg::SB_Z:ext_flag_jump_pkg::SB_V]
            == $past(instr_i.src[ext_flag_jump_pkg::SB_Z:ext_flag_jump_pkg::SB_V]))
        else $error("set-flags condition codes wrong");

    a_halt_only_bit: assert property (
        accept && !seq_bad && !aux_wr_i && kernel
        && (instr_i.kind == ext_flag_jump_pkg::op_set_flags)
        && instr_i.src[ext_flag_jump_pkg::SB_H]
        |=> core_halt_o && !instr_ready_o
            && (processor_status_word_o[31:1] == $past(cur_r.status[31:1])))
        else $error("halt changed other flags");

    a_user_no_enable: assert property (
        accept && !aux_wr_i && !kernel
        && (instr_i.kind == ext_flag_jump_pkg::op_set_flags)
        |=> $stable(processor_status_word_o[ext_flag_jump_pkg::SB_E2:ext_flag_jump_pkg::SB_H]))
        else $error("user mode changed halt or enables");

    a_keep_mode_bits: assert property (
        accept && !aux_wr_i && (instr_i.kind == ext_flag_jump_pkg::op_set_flags)
        |=> (processor_status_word_o & ext_flag_jump_pkg::KEEP_MASK)
            == ($past(cur_r.status) & ext_flag_jump_pkg::KEEP_MASK))
        else $error("set-flags touched mode bits");

    a_irq_hold_span: assert property (
        accept && (instr_i.kind == ext_flag_jump_pkg::op_set_flags)
        |-> irq_hold_o ##1 (irq_hold_o && !instr_ready_o))
        else $error("interrupt not held over set-flags");

    a_jump_target_go: assert property (
        accept && !seq_bad && hit && (instr_i.kind == ext_flag_jump_pkg::op_jump)
        && (is_link == instr_i.flag_sfx)
        |=> jump_o.taken && (jump_o.target == {$past(instr_i.src[31:1]), 1'b0}))
        else $error("jump target wrong");

    a_link_restore_one: assert property (
        accept && !seq_bad && hit && instr_i.src_link1 && instr_i.flag_sfx
        && (instr_i.kind == ext_flag_jump_pkg::op_jump)
        |=> (processor_status_word_o == $past(saved_i.level1_saved_status))
            && (branch_target_reg_o == $past(saved_i.level1_saved_target)))
        else $error("link restore wrong");

    a_link_error_raise: assert property (
        accept && !seq_bad && (instr_i.kind == ext_flag_jump_pkg::op_jump)
        && (is_link != instr_i.flag_sfx)
        |=> instr_error_o && !jump_o.taken)
        else $error("missing instruction error");

    a_slot_illegal_seq: assert property (
        accept && seq_bad |=> illegal_seq_o && !dest_we_o && !jump_o.taken)
        else $error("missing illegal sequence");

    a_always_taken: assert property (
        accept && !seq_bad && (instr_i.cond == ext_flag_jump_pkg::CC_AL)
        && (instr_i.kind == ext_flag_jump_pkg::op_jump)
        |=> jump_o.taken || instr_error_o)
        else $error("always condition not taken");

    a_high_cond_false: assert property (
        accept && instr_i.cond[4] && (instr_i.kind == ext_flag_jump_pkg::op_jump)
        |=> !jump_o.taken)
        else $error("reserved condition taken");

    a_slot_run_mode: assert property (
        accept && !seq_bad && (instr_i.kind == ext_flag_jump_pkg::op_jump)
        |=> instr_error_o
            || (jump_o.run_slot == ($past(instr_i.delay_sfx) || !jump_o.taken)))
        else $error("delay slot mode wrong");

    a_link_restore_two: assert property (
        accept && !seq_bad && hit && instr_i.src_link2 && !instr_i.src_link1
        && instr_i.flag_sfx && (instr_i.kind == ext_flag_jump_pkg::op_jump)
        |=> (processor_status_word_o == $past(saved_i.level2_saved_status))
            && (branch_target_reg_o == $past(saved_i.level2_saved_target)))
        else $error("second link restore wrong");

    a_resume_delay_flag: assert property (
        accept && !seq_bad && hit && is_link && instr_i.flag_sfx
        && (instr_i.kind == ext_flag_jump_pkg::op_jump)
        |=> jump_o.resume_delayed == processor_status_word_o[ext_flag_jump_pkg::SB_DE])
        else $error("delay state not resumed");

    a_untaken_stays: assert property (
        accept && !seq_bad && !hit && (instr_i.kind == ext_flag_jump_pkg::op_jump)
        |=> !jump_o.taken)
        else $error("untaken jump moved");

    c_halt_taken: cover property (
        accept && (instr_i.kind == ext_flag_jump_pkg::op_set_flags) ##1 core_halt_o);
    c_link_resume: cover property (jump_o.resume_delayed);
    c_delay_jump: cover property (jump_o.taken && jump_o.run_slot);
    c_bad_slot: cover property (illegal_seq_o);
    c_user_flags: cover property (
        accept && !kernel && (instr_i.kind == ext_flag_jump_pkg::op_set_flags));

endmodule : ext_flag_jump_execute

`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the extend, set-flags and jump execute block.
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_total++; \
    $display("wrong value %s exp %h got %h", nm, ex, got); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                          clk_i = 0;
    logic                          reset_n_i = 0;
    logic                          instr_valid_i = 0;
    ext_flag_jump_pkg::instr_t     instr_i = '0;
    ext_flag_jump_pkg::instr_t     ins;
    ext_flag_jump_pkg::saved_ctx_t saved_i = '0;
    ext_flag_jump_pkg::jump_t      jump_o;
    logic                          aux_wr_i = 0, aux_rd_i = 0;
    logic [31:0]                   aux_addr_i = '0, aux_wdata_i = '0;
    logic                          instr_ready_o, dest_we_o, irq_hold_o, core_halt_o;
    logic                          illegal_seq_o, instr_error_o, tk, d, hold;
    logic [31:0]                   aux_rdata_o, dest_o, psw, lsw, branch_target_reg, st, s, r;
    logic [15:0]                   lfsr_r = 16'hfc37;
    logic [4:0]                    c;
    int                            err_total = 0, n_compared = 0, i;
    always #5 clk_i = ~clk_i;
    ext_flag_jump_execute i_ext_flag_jump_execute (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .instr_valid_i(instr_valid_i), .instr_i(instr_i), .instr_ready_o(instr_ready_o),
        .saved_i(saved_i), .aux_wr_i(aux_wr_i), .aux_rd_i(aux_rd_i), .aux_addr_i(aux_addr_i),
        .aux_wdata_i(aux_wdata_i), .aux_rdata_o(aux_rdata_o), .dest_o(dest_o),
        .dest_we_o(dest_we_o), .jump_o(jump_o), .processor_status_word_o(psw),
        .legacy_status_word_o(lsw), .branch_target_reg_o(branch_target_reg), .irq_hold_o(irq_hold_o),
        .core_halt_o(core_halt_o), .illegal_seq_o(illegal_seq_o),
        .instr_error_o(instr_error_o));
    function logic [31:0] rnd();
        for (int k = 0; k < 32; k++) lfsr_r = {lfsr_r[14:0], ^(lfsr_r & 16'hb400)};
        return {lfsr_r, lfsr_r[7:0], lfsr_r[15:8]};
    endfunction : rnd
    function logic cc_hit(logic [4:0] q, logic [31:0] w);
        logic z, n, cy, v;
        {z, n, cy, v} = w[11:8];
        case (q)
            5'h00: return 1; 5'h01: return z; 5'h02: return !z; 5'h03: return !n;
            5'h04: return n; 5'h05: return cy; 5'h06: return !cy; 5'h07: return v;
            5'h08: return !v; 5'h09: return n == v && !z; 5'h0a: return n == v;
            5'h0b: return n != v; 5'h0c: return z || n != v; 5'h0d: return !cy && !z;
            5'h0e: return cy || z; 5'h0f: return !n && !z; default: return 0;
        endcase
    endfunction : cc_hit
    function ext_flag_jump_pkg::instr_t mk(ext_flag_jump_pkg::op_kind_t k, logic f,
                                           logic dl, logic [4:0] q, logic [31:0] sv);
        mk = '0;
        mk.kind = k;
        mk.flag_sfx = f;
        mk.delay_sfx = dl;
        mk.cond = q;
        mk.src = sv;
    endfunction : mk
    task automatic aux(input logic wr, input logic [31:0] a, input logic [31:0] dv);
        @(negedge clk_i);
        {aux_wr_i, aux_rd_i, aux_addr_i, aux_wdata_i} = {wr, !wr, a, dv};
        @(negedge clk_i);
        {aux_wr_i, aux_rd_i} = 2'b00;
    endtask : aux
    task automatic issue(input ext_flag_jump_pkg::instr_t x);
        int n;
        n = 0;
        @(negedge clk_i);
        while (instr_ready_o !== 1'b1 && n < 20) begin
            @(negedge clk_i);
            n++;
        end
        if (n == 20) err_total++;
        instr_valid_i = 1;
        instr_i = x;
        #1 hold = irq_hold_o;
        @(negedge clk_i);
        instr_valid_i = 0;
    endtask : issue
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        #100000;
        err_total++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(negedge clk_i);
        reset_n_i = 1;
        for (i = 0; i < 8; i++) begin
            st = rnd() & 32'h0000_0f06;
            aux(1, ext_flag_jump_pkg::ADDR_STATUS, st);
            s = (i < 2) ? 32'hff00_0000 : rnd();
            ins = mk(ext_flag_jump_pkg::zero_extend_byte_op, !i[2], 0, 0, s);
            if (i[0]) ins.kind = ext_flag_jump_pkg::zero_extend_half_op;
            issue(ins);
            r = s & (i[0] ? 32'h0000_ffff : 32'h0000_00ff);
            `CHK("dest", r, dest_o)
            `CHK("dest_we", 1'b1, dest_we_o)
            if (!i[2]) st[11:10] = {r == 0, 1'b0};
            `CHK("status", st, psw)
        end
        $display("test extend done");
        for (i = 0; i < 4; i++) begin
            st = rnd() & 32'h0000_1f7e;
            st[7] = (i == 3);
            aux(1, ext_flag_jump_pkg::ADDR_STATUS, st);
            s = (rnd() & 32'hffff_fffe) | (i == 3);
            issue(mk(ext_flag_jump_pkg::op_set_flags, 0, 0, 0, s));
            `CHK("hold", 1'b1, hold)
            `CHK("ready", 1'b0, instr_ready_o)
            st[11:8] = s[11:8];
            if (i != 3) st[2:1] = s[2:1];
            `CHK("status", st, psw)
            `CHK("legacy", {st[11:8], st[2:0], ext_flag_jump_pkg::LEG_ZERO}, lsw)
        end
        aux(0, ext_flag_jump_pkg::ADDR_STATUS, 0);
        `CHK("read status", st, aux_rdata_o)
        aux(0, ext_flag_jump_pkg::ADDR_LEGACY, 0);
        `CHK("read legacy", {st[11:8], st[2:0], ext_flag_jump_pkg::LEG_ZERO}, aux_rdata_o)
        aux(0, 32'h0000_0005, 0);
        `CHK("read unmapped", 32'h0000_0000, aux_rdata_o)
        $display("test set flags done");
        for (i = 0; i < 33; i++) begin
            c = (i == 32) ? 5'h13 : {1'b0, i[3:0]};
            st = rnd() & 32'h0000_0f06;
            aux(1, ext_flag_jump_pkg::ADDR_STATUS, st);
            s = rnd();
            d = s[5];
            issue(mk(ext_flag_jump_pkg::op_jump, 0, d, c, s));
            tk = cc_hit(c, st);
            `CHK("taken", tk, jump_o.taken)
            if (tk) `CHK("target", s & 32'hffff_fffe, jump_o.target)
            `CHK("slot", d | !tk, jump_o.run_slot)
            if (d) issue(mk(ext_flag_jump_pkg::op_other, 0, 0, 0, 0));
        end
        for (i = 0; i < 4; i++) begin
            issue(mk(ext_flag_jump_pkg::op_jump, 0, 1, 0, rnd()));
            ins = mk(ext_flag_jump_pkg::op_other, 0, 0, 0, 0);
            {ins.is_branch, ins.is_loop, ins.is_irq_return, ins.has_limm} = 4'b1000 >> i;
            issue(ins);
            `CHK("illegal", 1'b1, illegal_seq_o)
        end
        $display("test jump done");
        for (i = 0; i < 4; i++) begin
            saved_i = {rnd() & 32'h0000_0f46, rnd() & 32'h0000_0f46, rnd(), rnd()};
            ins = mk(ext_flag_jump_pkg::op_jump, i != 2, 0, 0, rnd());
            ins.src_link1 = (i == 0 || i == 2);
            ins.src_link2 = (i == 1);
            issue(ins);
            if (i < 2) begin
                st = i ? saved_i.level2_saved_status : saved_i.level1_saved_status;
                r = i ? saved_i.level2_saved_target : saved_i.level1_saved_target;
                `CHK("link taken", 1'b1, jump_o.taken)
                `CHK("restored", st, psw)
                `CHK("bta", r, branch_target_reg)
                `CHK("resume", st[6], jump_o.resume_delayed)
            end else begin
                `CHK("error", 1'b1, instr_error_o)
                `CHK("no jump", 1'b0, jump_o.taken)
            end
            issue(mk(ext_flag_jump_pkg::op_other, 0, 0, 0, 0));
        end
        $display("test link done");
        st = rnd() & 32'h0000_0f06;
        aux(1, ext_flag_jump_pkg::ADDR_STATUS, st);
        issue(mk(ext_flag_jump_pkg::op_set_flags, 0, 0, 0, rnd() | 32'h0000_0001));
        `CHK("halt status", st | 32'h0000_0001, psw)
        `CHK("halt", 1'b1, core_halt_o)
        repeat (3) @(negedge clk_i);
        `CHK("halt ready", 1'b0, instr_ready_o)
        $display("test halt done");
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
